// ===== src/prot_defines.svh
// constants for the protection unit control link and its controller
`ifndef PROT_DEFINES_SVH
`define PROT_DEFINES_SVH
`define NREG        8
`define IDX_W       3
`define HI_W        27
`define HI_LSB      5
`define RA_W        8
`define OFF_CTRL    8'h94
`define OFF_RNR     8'h98
`define OFF_RBAR    8'h9C
`define OFF_RLAR    8'hA0
`define CTRL_EN     0
`define CTRL_HFNMI  1
`define CTRL_PRIV   2
`define CTRL_W      3
`define CTRL_RST    3'h0
`define RNR_W       8
`define RNR_RST     8'h00
`define RBAR_VALID  4
`define RBAR_REG_W  4
`define RLAR_EN     0
`define SCS_LO      32'hE000E000
`define SCS_HI      32'hE000EFFF
`define VT_LO       32'h00000000
`define VT_HI       32'h000003FF
`define A_CMD       12'h000
`define A_ADDR      12'h004
`define A_WDATA     12'h008
`define A_RDATA     12'h00C
`define A_RESULT    12'h010
`define A_STAT      12'h014
`define A_MASK      12'h018
`define CMD_START   0
`define CMD_ACC     1
`define CMD_WR      2
`define CMD_PRIV    3
`define CMD_FETCH   4
`define CMD_HFNMI   5
`define CMD_OFF_LSB 8
`define ST_DONE     0
`define ST_FAULT    1
`define ST_REJECT   2
`define ST_W        3
`define RES_FAULT   0
`define RES_DEF     1
`define RES_NOEXEC  2
`define RES_STRONG  3
`define RES_HIT     4
`define RES_BUSY    5
`define RES_REG_LSB 8
`endif

// ===== src/prot_pkg.sv
// types shared by the protection unit, its controller and the matcher
package prot_pkg;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT  = 2'b11,
		ST_DONE  = 2'b10
	} ctl_state_e;
	typedef logic [26:0] addr_hi_t;
	typedef logic [7:0]  region_t;
endpackage

// ===== src/prot_link_if.sv
// link between the protection unit and the core-side controller
`timescale 1ns/1ns
interface prot_link_if;
	logic        reg_req;
	logic        reg_wr;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        reg_ack;
	logic        acc_req;
	logic [31:0] acc_addr;
	logic        acc_priv;
	logic        acc_fetch;
	logic        acc_hfnmi;
	logic        acc_ack;
	logic        acc_fault;
	logic        acc_default;
	logic        acc_noexec;
	logic        acc_strong;
	logic        acc_hit;
	logic [7:0]  acc_region;
	modport unit (
		input  reg_req, reg_wr, reg_addr, reg_wdata, acc_req, acc_addr, acc_priv, acc_fetch, acc_hfnmi,
		output reg_rdata, reg_ack, acc_ack, acc_fault, acc_default, acc_noexec, acc_strong, acc_hit, acc_region
	);
	modport core (
		output reg_req, reg_wr, reg_addr, reg_wdata, acc_req, acc_addr, acc_priv, acc_fetch, acc_hfnmi,
		input  reg_rdata, reg_ack, acc_ack, acc_fault, acc_default, acc_noexec, acc_strong, acc_hit, acc_region
	);
endinterface

// ===== src/region_match.sv
// per-region address compare with overlap detection
`timescale 1ns/1ns
`include "prot_defines.svh"
module region_match
	import prot_pkg::*;
(
	// address under test
	input  wire addr_hi_t i_addr_hi,
	// region table
	input  wire addr_hi_t i_base [`NREG],
	input  wire addr_hi_t i_limit [`NREG],
	input  wire logic     i_en [`NREG],
	// result
	output logic          o_hit,
	output logic          o_multi,
	output region_t       o_index
);
	logic [`NREG-1:0] hits;

	genvar g;
	generate
		for (g = 0; g < `NREG; g++) begin : g_cmp
			assign hits[g] = i_en[g] && (i_addr_hi >= i_base[g]) && (i_addr_hi <= i_limit[g]);
		end
	endgenerate

	assign o_hit   = |hits;
	assign o_multi = |(hits & (hits - `NREG'(1)));

	always_comb begin
		o_index = '0;
		for (int i = 0; i < `NREG; i++) begin
			if (hits[i]) begin
				o_index = region_t'(i);
			end
		end
	end
endmodule

// ===== src/prot_unit.sv
// protection unit: control and region select registers and access check
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "prot_defines.svh"
// Behaviour
// - enable clear means default map for all; the code faults system space fetches even then
// - enabled, no background: unmatched access faults
// - background map only for privileged accesses
// - matching enabled region beats background map
// - background bit ignored while disabled
// - no checking in fault handlers unless enabled
// - handler bit set keeps checking in handlers
// - software never sets handler bit while disabled
// - system space always execute-never, strongly ordered
// - system space and vectors always permitted; the code faults system space fetches
// - background, no regions: privileged only succeeds
// - enabling needs a region or background map
// - select field picks base and limit view
// - software never selects unimplemented region
// - software selects region before base access
// - prohibited access raises hard fault
// - valid base write updates region select
module prot_unit
	import prot_pkg::*;
(
	// clock and reset
	input  wire logic  I_CLK,
	input  wire logic  I_RSTN,
	// link to the core side
	prot_link_if.unit  link,
	// status towards the core
	output logic       O_HARD_FAULT,
	output logic       O_PROT_ENABLE
);
	logic [`CTRL_W-1:0] ctrl_reg;
	logic [`RNR_W-1:0]  rnr_reg;
	addr_hi_t           base_reg [`NREG];
	addr_hi_t           limit_reg [`NREG];
	logic               en_reg [`NREG];

	logic               wr_ctrl;
	logic               wr_rnr;
	logic               wr_rbar;
	logic               wr_rlar;
	logic               rbar_valid;
	logic [`RNR_W-1:0]  wr_sel;
	logic               sel_ok;
	logic [`IDX_W-1:0]  sel_idx;

	logic               hit;
	logic               multi;
	region_t            hit_idx;
	logic               in_scs;
	logic               in_vt;
	logic               checking;
	logic               fault_next;
	logic               def_next;
	logic               hit_next;

	logic [31:0]        rdata_reg;
	logic               rack_reg;
	logic               aack_reg;
	logic               fault_reg;
	logic               def_reg;
	logic               noexec_reg;
	logic               strong_reg;
	logic               hitr_reg;
	region_t            region_reg;

	// register port decode
	assign wr_ctrl    = link.reg_req && link.reg_wr && (link.reg_addr == `OFF_CTRL);
	assign wr_rnr     = link.reg_req && link.reg_wr && (link.reg_addr == `OFF_RNR);
	assign wr_rbar    = link.reg_req && link.reg_wr && (link.reg_addr == `OFF_RBAR);
	assign wr_rlar    = link.reg_req && link.reg_wr && (link.reg_addr == `OFF_RLAR);
	assign rbar_valid = link.reg_wdata[`RBAR_VALID];

	// a valid base write retargets the region before the base lands
	assign wr_sel  = (wr_rbar && rbar_valid) ?
		`RNR_W'(link.reg_wdata[`RBAR_REG_W-1:0]) : rnr_reg;
	// out-of-range selects leave the table untouched
	assign sel_ok  = (wr_sel < `RNR_W'(`NREG));
	assign sel_idx = wr_sel[`IDX_W-1:0];

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl_reg <= `CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_reg <= link.reg_wdata[`CTRL_W-1:0];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rnr_reg <= `RNR_RST;
		end else if (wr_rnr) begin
			rnr_reg <= link.reg_wdata[`RNR_W-1:0];
		end else if (wr_rbar && rbar_valid) begin
			rnr_reg <= wr_sel;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `NREG; g++) begin : g_region
			always_ff @(posedge I_CLK or negedge I_RSTN) begin
				if (!I_RSTN) begin
					base_reg[g]  <= '0;
					limit_reg[g] <= '0;
					en_reg[g]    <= 1'b0;
				end else if (sel_ok && (sel_idx == `IDX_W'(g))) begin
					if (wr_rbar) begin
						base_reg[g] <= link.reg_wdata[31:`HI_LSB];
					end
					if (wr_rlar) begin
						limit_reg[g] <= link.reg_wdata[31:`HI_LSB];
						en_reg[g]    <= link.reg_wdata[`RLAR_EN];
					end
				end
			end
		end
	endgenerate

	// register reads answer one cycle after the request
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rdata_reg <= '0;
		end else if (link.reg_req && !link.reg_wr) begin
			if (link.reg_addr == `OFF_CTRL) begin
				rdata_reg <= 32'(ctrl_reg);
			end else if (link.reg_addr == `OFF_RNR) begin
				rdata_reg <= 32'(rnr_reg);
			end else if (link.reg_addr == `OFF_RBAR && sel_ok) begin
				rdata_reg <= {base_reg[sel_idx], `HI_LSB'(0)};
			end else if (link.reg_addr == `OFF_RLAR && sel_ok) begin
				rdata_reg <= {limit_reg[sel_idx], `HI_LSB'(0)} | 32'(en_reg[sel_idx]);
			end else begin
				rdata_reg <= '0;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rack_reg <= 1'b0;
		end else begin
			rack_reg <= link.reg_req;
		end
	end

	region_match u_match (
		.i_addr_hi (link.acc_addr[31:`HI_LSB]),
		.i_base    (base_reg),
		.i_limit   (limit_reg),
		.i_en      (en_reg),
		.o_hit     (hit),
		.o_multi   (multi),
		.o_index   (hit_idx)
	);

	assign in_scs = (link.acc_addr >= `SCS_LO) && (link.acc_addr <= `SCS_HI);
	assign in_vt  = (link.acc_addr >= `VT_LO) && (link.acc_addr <= `VT_HI);

	// the background bit is never looked at unless checking is on
	assign checking = ctrl_reg[`CTRL_EN] &&
		(!link.acc_hfnmi || ctrl_reg[`CTRL_HFNMI]);

	always_comb begin
		fault_next = 1'b0;
		def_next   = 1'b0;
		hit_next   = 1'b0;
		if (in_scs && link.acc_fetch) begin
			fault_next = 1'b1;
		end else if (!checking) begin
			def_next = 1'b1;
		end else if (in_scs || in_vt) begin
			def_next = 1'b1;
		end else if (multi) begin
			fault_next = 1'b1;
		end else if (hit) begin
			hit_next = 1'b1;
		end else if (ctrl_reg[`CTRL_PRIV] && link.acc_priv) begin
			def_next = 1'b1;
		end else begin
			fault_next = 1'b1;
		end
	end

	// access answer, registered one cycle after the request
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			aack_reg   <= 1'b0;
			fault_reg  <= 1'b0;
			def_reg    <= 1'b0;
			noexec_reg <= 1'b0;
			strong_reg <= 1'b0;
			hitr_reg   <= 1'b0;
			region_reg <= '0;
		end else begin
			aack_reg <= link.acc_req;
			if (link.acc_req) begin
				fault_reg  <= fault_next;
				def_reg    <= def_next;
				noexec_reg <= in_scs;
				strong_reg <= in_scs;
				hitr_reg   <= hit_next;
				region_reg <= hit_next ? hit_idx : '0;
			end
		end
	end

	assign link.reg_rdata   = rdata_reg;
	assign link.reg_ack     = rack_reg;
	assign link.acc_ack     = aack_reg;
	assign link.acc_fault   = fault_reg;
	assign link.acc_default = def_reg;
	assign link.acc_noexec  = noexec_reg;
	assign link.acc_strong  = strong_reg;
	assign link.acc_hit     = hitr_reg;
	assign link.acc_region  = region_reg;
	// hard fault is a one-cycle pulse with the answer
	assign O_HARD_FAULT     = aack_reg && fault_reg;
	assign O_PROT_ENABLE    = ctrl_reg[`CTRL_EN];
endmodule

// ===== src/prot_core.sv
// core-side controller: apb command registers driving the protection link
`timescale 1ns/1ns
`include "prot_defines.svh"
module prot_core
	import prot_pkg::*;
(
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RSTN,
	// apb slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic [31:0]      O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	output logic             O_IRQ,
	// link to the protection unit
	prot_link_if.core        link
);
	ctl_state_e        state_reg;
	logic [31:0]       cmd_reg;
	logic [31:0]       addr_reg;
	logic [31:0]       wdata_reg;
	logic [31:0]       rdata_reg;
	logic [31:0]       result_reg;
	logic [`ST_W-1:0]  stat_reg;
	logic [`ST_W-1:0]  mask_reg;
	logic [`RNR_W-1:0] shadow_rnr;
	logic [`NREG-1:0]  shadow_en;

	logic              apb_wr;
	logic              apb_rd;
	logic              mapped;
	logic              start;
	logic              is_reg_wr;
	logic [7:0]        off;
	logic              bad;
	logic [`ST_W-1:0]  set;
	logic [`ST_W-1:0]  clr;

	assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
	assign apb_rd = I_PSEL && I_PENABLE && !I_PWRITE;
	assign mapped = (I_PADDR == `A_CMD) || (I_PADDR == `A_ADDR) || (I_PADDR == `A_WDATA) ||
		(I_PADDR == `A_RDATA) || (I_PADDR == `A_RESULT) || (I_PADDR == `A_STAT) || (I_PADDR == `A_MASK);
	assign start     = apb_wr && (I_PADDR == `A_CMD) && I_PWDATA[`CMD_START] && (state_reg == ST_IDLE);
	assign is_reg_wr = !I_PWDATA[`CMD_ACC] && I_PWDATA[`CMD_WR];
	assign off       = I_PWDATA[`CMD_OFF_LSB +: 8];

	// orders the unit would turn into undefined behaviour are refused here
	always_comb begin
		bad = 1'b0;
		if (is_reg_wr && off == `OFF_CTRL) begin
			bad = (wdata_reg[`CTRL_HFNMI] && !wdata_reg[`CTRL_EN]) ||
				(wdata_reg[`CTRL_EN] && !wdata_reg[`CTRL_PRIV] && shadow_en == '0);
		end else if (is_reg_wr && off == `OFF_RNR) begin
			bad = wdata_reg[`RNR_W-1:0] >= `RNR_W'(`NREG);
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE:  state_reg <= (start && !bad) ? ST_ISSUE : ST_IDLE;
				ST_ISSUE: state_reg <= ST_WAIT;
				ST_WAIT:  state_reg <= (link.reg_ack || link.acc_ack) ? ST_DONE : ST_WAIT;
				default:  state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			cmd_reg   <= '0;
			addr_reg  <= '0;
			wdata_reg <= '0;
			mask_reg  <= '0;
		end else if (apb_wr) begin
			if (I_PADDR == `A_CMD && start) begin
				cmd_reg <= I_PWDATA;
			end else if (I_PADDR == `A_ADDR) begin
				addr_reg <= I_PWDATA;
			end else if (I_PADDR == `A_WDATA) begin
				wdata_reg <= I_PWDATA;
			end else if (I_PADDR == `A_MASK) begin
				mask_reg <= I_PWDATA[`ST_W-1:0];
			end
		end
	end

	// shadow of the select and enables, kept from our own writes
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			shadow_rnr <= `RNR_RST;
			shadow_en  <= '0;
		end else if (state_reg == ST_ISSUE && !cmd_reg[`CMD_ACC] && cmd_reg[`CMD_WR]) begin
			if (cmd_reg[`CMD_OFF_LSB +: 8] == `OFF_RNR) begin
				shadow_rnr <= wdata_reg[`RNR_W-1:0];
			end else if (cmd_reg[`CMD_OFF_LSB +: 8] == `OFF_RBAR && wdata_reg[`RBAR_VALID]) begin
				shadow_rnr <= `RNR_W'(wdata_reg[`RBAR_REG_W-1:0]);
			end else if (cmd_reg[`CMD_OFF_LSB +: 8] == `OFF_RLAR && shadow_rnr < `RNR_W'(`NREG)) begin
				shadow_en[shadow_rnr[`IDX_W-1:0]] <= wdata_reg[`RLAR_EN];
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rdata_reg  <= '0;
			result_reg <= '0;
		end else if (state_reg == ST_WAIT && link.reg_ack) begin
			rdata_reg <= link.reg_rdata;
		end else if (state_reg == ST_WAIT && link.acc_ack) begin
			result_reg <= (32'(link.acc_fault) << `RES_FAULT) | (32'(link.acc_default) << `RES_DEF) |
				(32'(link.acc_noexec) << `RES_NOEXEC) | (32'(link.acc_strong) << `RES_STRONG) |
				(32'(link.acc_hit) << `RES_HIT) | (32'(link.acc_region) << `RES_REG_LSB);
		end
	end

	// sticky events; a set in the clearing cycle survives
	always_comb begin
		set = '0;
		set[`ST_DONE]   = (state_reg == ST_WAIT) && (link.reg_ack || link.acc_ack);
		set[`ST_FAULT]  = (state_reg == ST_WAIT) && link.acc_ack && link.acc_fault;
		set[`ST_REJECT] = start && bad;
		clr = (apb_wr && I_PADDR == `A_STAT) ? I_PWDATA[`ST_W-1:0] : '0;
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			stat_reg <= '0;
		end else begin
			stat_reg <= (stat_reg & ~clr) | set;
		end
	end

	always_comb begin
		O_PRDATA = '0;
		if (!apb_rd) begin
			O_PRDATA = '0;
		end else if (I_PADDR == `A_CMD) begin
			O_PRDATA = cmd_reg;
		end else if (I_PADDR == `A_ADDR) begin
			O_PRDATA = addr_reg;
		end else if (I_PADDR == `A_WDATA) begin
			O_PRDATA = wdata_reg;
		end else if (I_PADDR == `A_RDATA) begin
			O_PRDATA = rdata_reg;
		end else if (I_PADDR == `A_RESULT) begin
			O_PRDATA = result_reg | (32'(state_reg != ST_IDLE) << `RES_BUSY);
		end else if (I_PADDR == `A_STAT) begin
			O_PRDATA = 32'(stat_reg);
		end else if (I_PADDR == `A_MASK) begin
			O_PRDATA = 32'(mask_reg);
		end
	end

	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
	assign O_IRQ     = |(stat_reg & mask_reg);

	assign link.reg_req   = (state_reg == ST_ISSUE) && !cmd_reg[`CMD_ACC];
	assign link.reg_wr    = cmd_reg[`CMD_WR];
	assign link.reg_addr  = cmd_reg[`CMD_OFF_LSB +: 8];
	assign link.reg_wdata = wdata_reg;
	assign link.acc_req   = (state_reg == ST_ISSUE) && cmd_reg[`CMD_ACC];
	assign link.acc_addr  = addr_reg;
	assign link.acc_priv  = cmd_reg[`CMD_PRIV];
	assign link.acc_fetch = cmd_reg[`CMD_FETCH];
	assign link.acc_hfnmi = cmd_reg[`CMD_HFNMI];
endmodule

// ===== test/prot_link_sva.sv
// assertions on the link between the protection unit and its controller
`timescale 1ns/1ns
`include "prot_defines.svh"
module prot_link_sva (
	// clock and reset
	input wire logic        I_CLK,
	input wire logic        I_RSTN,
	// link signals
	input wire logic        reg_req,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic        reg_ack,
	input wire logic        acc_req,
	input wire logic [31:0] acc_addr,
	input wire logic        acc_priv,
	input wire logic        acc_fetch,
	input wire logic        acc_hfnmi,
	input wire logic        acc_ack,
	input wire logic        acc_fault,
	input wire logic        acc_default,
	input wire logic        acc_noexec,
	input wire logic        acc_strong,
	input wire logic        acc_hit
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);
	logic [2:0] ctl_reg;
	logic       scs;
	logic       chk;
	// only writes that reach the unit count; rejected ones never do
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctl_reg <= 3'h0;
		end else if (reg_req && reg_wr && reg_addr == `OFF_CTRL) begin
			ctl_reg <= reg_wdata[2:0];
		end
	end
	assign scs = acc_addr >= `SCS_LO && acc_addr <= `SCS_HI;
	assign chk = ctl_reg[0] && !(acc_hfnmi && !ctl_reg[1]);
	property p_reg_ack;
		reg_req |=> reg_ack;
	endproperty
	a_reg_ack: assert property (p_reg_ack) else $error("register request not acknowledged");
	property p_acc_ack;
		acc_req |=> acc_ack;
	endproperty
	a_acc_ack: assert property (p_acc_ack) else $error("access request not acknowledged");
	property p_scs_attr;
		acc_req && scs |=> acc_noexec && acc_strong;
	endproperty
	a_scs_attr: assert property (p_scs_attr) else $error("system space attributes missing");
	property p_off;
		acc_req && !ctl_reg[0] && !(acc_fetch && scs) |=> acc_default && !acc_fault;
	endproperty
	a_off: assert property (p_off) else $error("disabled unit did not use default map");
	property p_handler;
		acc_req && ctl_reg[0] && !ctl_reg[1] && acc_hfnmi && !(acc_fetch && scs) |=> acc_default && !acc_fault;
	endproperty
	a_handler: assert property (p_handler) else $error("handler access was checked");
	property p_always_ok;
		acc_req && chk && ((scs && !acc_fetch) || acc_addr <= `VT_HI) |=> !acc_fault;
	endproperty
	a_always_ok: assert property (p_always_ok) else $error("system space or vector access faulted");
	property p_unpriv;
		acc_req && chk && !acc_priv && !scs && acc_addr > `VT_HI |=> !acc_default;
	endproperty
	a_unpriv: assert property (p_unpriv) else $error("unprivileged access used background map");
	property p_hit_wins;
		acc_ack && acc_hit |-> !acc_fault && !acc_default;
	endproperty
	a_hit_wins: assert property (p_hit_wins) else $error("region hit not preferred");
	property p_ctl_read;
		reg_req && !reg_wr && reg_addr == `OFF_CTRL |=> reg_rdata == {29'h0, ctl_reg};
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control read value wrong");
	property p_sel_read;
		reg_req && !reg_wr && reg_addr == `OFF_RNR |=> reg_rdata[31:8] == 24'h0;
	endproperty
	a_sel_read: assert property (p_sel_read) else $error("select reserved bits not zero");
endmodule

// ===== test/tb.sv
// self-checking bench for the protection unit and its apb controller
`timescale 1ns/1ns
`include "prot_defines.svh"
module tb;
	logic        I_CLK = 1'b0;
	logic        I_RSTN = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, st, a;
	logic        pready, pslverr, irq, hard_fault, prot_en;
	int          failures = 0, checks = 0, seed = 22792, hf_cnt = 0, nfault = 0;
	int          ctl = 0, sel = 0, base [8], lim [8], len [8];
	int          modes [6] = '{0, 4, 1, 5, 3, 7};
	logic [31:0] addrs [8] = '{32'h20000000, 32'h20000900, 32'h20001000, 32'h40000100,
		32'h60000000, 32'hE000ED00, 32'h00000100, 32'h30000000};
	prot_link_if link ();
	prot_unit prot_unit_i (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .link(link), .O_HARD_FAULT(hard_fault),
		.O_PROT_ENABLE(prot_en));
	prot_core prot_core_i (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .O_IRQ(irq), .link(link));
	prot_link_sva prot_link_sva_i (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .reg_req(link.reg_req),
		.reg_wr(link.reg_wr), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .acc_req(link.acc_req),
		.acc_addr(link.acc_addr), .acc_priv(link.acc_priv), .acc_fetch(link.acc_fetch),
		.acc_hfnmi(link.acc_hfnmi), .acc_ack(link.acc_ack), .acc_fault(link.acc_fault),
		.acc_default(link.acc_default), .acc_noexec(link.acc_noexec), .acc_strong(link.acc_strong),
		.acc_hit(link.acc_hit));
	always #20 I_CLK = ~I_CLK;
	always @(posedge I_CLK) if (hard_fault === 1'b1) hf_cnt++;
	task automatic end_of_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one transfer then an idle cycle, so back-to-back calls never collide
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge I_CLK);
		penable <= 1'b1;
		@(posedge I_CLK);
		while (pready !== 1'b1) @(posedge I_CLK);
		rd = prdata;
		st[31] = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge I_CLK);
	endtask
	task automatic cmd(input logic [31:0] c, input logic [2:0] exp);
		int n;
		apb(1'b1, `A_CMD, c);
		n = 0;
		st = 32'h0;
		while (st[0] !== 1'b1 && st[2] !== 1'b1 && n < 40) begin
			apb(1'b0, `A_STAT, 32'h0);
			st = rd;
			n++;
		end
		chk(st[2:0], exp);
		chk(irq, exp[1]); // mask holds only the fault bit
		apb(1'b1, `A_STAT, 32'h7);
	endtask
	task automatic lr(input logic [7:0] off, input logic [31:0] exp);
		cmd({16'h0, off, 8'h01}, 3'b001);
		apb(1'b0, `A_RDATA, 32'h0);
		chk(rd, exp);
	endtask
	task automatic wr_reg(input logic [7:0] off, input logic [31:0] d);
		logic rej;
		int any;
		rej = 1'b0;
		any = 0;
		for (int i = 0; i < 8; i++) any += len[i];
		if (off == `OFF_CTRL) begin
			rej = (d[1] && !d[0]) || (d[0] && !d[2] && any == 0);
			if (!rej) ctl = d[2:0];
		end else if (off == `OFF_RNR) begin
			rej = d[7:0] >= 8;
			if (!rej) sel = d[7:0];
		end else if (off == `OFF_RBAR) begin
			if (d[4]) sel = d[3:0];
			base[sel] = d[31:5];
		end else begin
			lim[sel] = d[31:5];
			len[sel] = d[0];
		end
		apb(1'b1, `A_WDATA, d);
		cmd({16'h0, off, 8'h05}, {rej, 1'b0, !rej});
	endtask
	// f holds handler, fetch and privileged flags
	task automatic acc(input logic [31:0] ad, input logic [2:0] f);
		logic [4:0] e;
		logic       scs;
		int         hits, idx;
		hits = 0;
		idx = 0;
		scs = ad >= `SCS_LO && ad <= `SCS_HI;
		for (int i = 0; i < 8; i++) begin
			if (len[i] == 1 && ad[31:5] >= base[i] && ad[31:5] <= lim[i]) begin
				hits++;
				idx = i;
			end
		end
		e = {1'b0, scs, scs, 2'b00};
		if (f[1] && scs) e[0] = 1'b1;
		else if (ctl[0] == 0 || (f[2] && ctl[1] == 0) || scs || ad <= `VT_HI) e[1] = 1'b1;
		else if (hits > 1) e[0] = 1'b1;
		else if (hits == 1) e[4] = 1'b1;
		else if (ctl[2] == 1 && f[0]) e[1] = 1'b1;
		else e[0] = 1'b1;
		nfault += e[0];
		apb(1'b1, `A_ADDR, ad);
		cmd({26'h0, f, 3'b011}, {1'b0, e[0], 1'b1});
		apb(1'b0, `A_RESULT, 32'h0);
		chk(rd[5:0], {1'b0, e});
		chk(rd[15:8], e[4] ? 8'(idx) : 8'h00);
		chk(prot_en, ctl[0]);
	endtask
	initial begin
		repeat (40000) @(posedge I_CLK);
		failures++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge I_CLK);
		I_RSTN <= 1'b1;
		@(posedge I_CLK);
		lr(`OFF_CTRL, 32'h0);
		lr(`OFF_RNR, 32'h0);
		wr_reg(`OFF_CTRL, 32'hFFFFFFFC);
		lr(`OFF_CTRL, 32'h4);
		wr_reg(`OFF_CTRL, 32'h1);
		wr_reg(`OFF_CTRL, 32'h2);
		wr_reg(`OFF_RNR, 32'h8);
		apb(1'b0, 12'h01C, 32'h0);
		chk(st[31], 1'b1);
		apb(1'b1, `A_MASK, 32'h2);
		// region 0 and 1 overlap on purpose; region 2 chosen by the base view
		wr_reg(`OFF_RNR, 32'h0);
		wr_reg(`OFF_RBAR, 32'h20000000);
		wr_reg(`OFF_RLAR, 32'h20000FE1);
		wr_reg(`OFF_RBAR, 32'h20000811);
		wr_reg(`OFF_RLAR, 32'h200017E1);
		lr(`OFF_RNR, 32'h1);
		wr_reg(`OFF_RBAR, 32'h40000012);
		wr_reg(`OFF_RLAR, 32'h40007FE1);
		wr_reg(`OFF_RNR, 32'h00000F00);
		lr(`OFF_RBAR, 32'h20000000);
		lr(`OFF_RLAR, 32'h20000FE1);
		foreach (modes[m]) begin
			wr_reg(`OFF_CTRL, modes[m]);
			for (int k = 0; k < 30; k++) begin
				a = addrs[$unsigned($random(seed)) % 8] + ($random(seed) & 32'h7C);
				acc(a, 3'($random(seed)));
			end
			$display("mode %0d done", modes[m]);
		end
		chk(hf_cnt, nfault);
		end_of_test();
	end
endmodule
